//--- rtl/io_pin_regs.svh
// constants for the pin group block
`ifndef IO_PIN_REGS_SVH
`define IO_PIN_REGS_SVH
`define PIN_COUNT 8
`define LATCH_POR_VALUE 8'h00
`define ZERO_PINS 8'h00
`define CFG_DONE_CYCLES 4'h4
`endif

//--- rtl/io_pin_pkg.sv
// types for the pin group block
`default_nettype none
package io_pin_pkg;
  typedef enum logic [1:0] {
    IRQ_NONE = 2'h0,
    IRQ_RISE = 2'h1,
    IRQ_FALL = 2'h2,
    IRQ_BOTH = 2'h3
  } irq_mode_type;
  typedef enum logic [1:0] {
    SYNC_DOUBLE = 2'h0,
    SYNC_SINGLE = 2'h1,
    SYNC_TRANSPARENT = 2'h2
  } in_sync_type;
  typedef enum logic [1:0] {
    OUT_TRANSPARENT = 2'h0,
    OUT_SINGLE = 2'h1,
    OUT_CLOCK = 2'h2,
    OUT_CLOCK_INV = 2'h3
  } out_mode_type;
  typedef enum logic [1:0] {
    CFG_RESET = 2'h0,
    CFG_DRIVE = 2'h1,
    CFG_INIT = 2'h2,
    CFG_RUN = 2'h3
  } cfg_state_type;
endpackage
`default_nettype wire

//--- rtl/io_pin_sync_and_edge_irq.sv
// pin group: init latch, in/out sync, edge events, port interrupt
`include "io_pin_regs.svh"
`default_nettype none
module io_pin_sync_and_edge_irq
  import io_pin_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // pin side
  input wire logic [`PIN_COUNT-1:0] i_pin_in,
  output logic [`PIN_COUNT-1:0] o_pin_out,
  output logic [`PIN_COUNT-1:0] o_pin_oe,
  // output data source and drive control
  input wire logic [`PIN_COUNT-1:0] i_init_value,
  input wire logic [`PIN_COUNT-1:0] i_hw_out_conn,
  input wire logic [`PIN_COUNT-1:0] i_hw_out,
  input wire logic [`PIN_COUNT-1:0] i_hw_oe_used,
  input wire logic [`PIN_COUNT-1:0] i_hw_oe,
  input wire logic [`PIN_COUNT-1:0] i_drive_en,
  // software access to the data latch
  input wire logic i_sw_write,
  input wire logic [`PIN_COUNT-1:0] i_sw_data,
  output logic [`PIN_COUNT-1:0] o_output_data_latch,
  // input path control
  input wire logic [`PIN_COUNT-1:0] i_in_buf_en,
  input wire logic [`PIN_COUNT-1:0] i_hw_in_conn,
  input wire logic [1:0] i_in_sync,
  // output path control
  input wire logic [1:0] i_out_mode,
  input wire logic i_out_clock,
  // interrupt mode, two bits per pin
  input wire logic [2*`PIN_COUNT-1:0] i_irq_mode,
  // input level results
  output logic [`PIN_COUNT-1:0] o_pin_level_state,
  output logic [`PIN_COUNT-1:0] o_hw_in,
  // event clear and status
  input wire logic i_clear_pin_events_call,
  output logic [`PIN_COUNT-1:0] o_clear_result,
  output logic o_port_irq,
  output logic o_cfg_done
);
  cfg_state_type cfg_q, cfg_d;
  logic [3:0] cnt_q, cnt_d;
  logic [`PIN_COUNT-1:0] latch_q, latch_d;
  logic [`PIN_COUNT-1:0] s1_q, s2_q, prev_q, prev_d;
  logic [`PIN_COUNT-1:0] ev_q, ev_d, res_q, res_d;
  logic [`PIN_COUNT-1:0] outr_q, outr_d;
  logic [`PIN_COUNT-1:0] lvl, rise, fall, hit, outsrc;
  in_sync_type isync;
  out_mode_type omode;
  // per-pin results of the decode functions and the synchroniser next values
  logic [`PIN_COUNT-1:0] pin_drv;
  logic [`PIN_COUNT-1:0] pin_en;
  logic [`PIN_COUNT-1:0] qual;
  logic [`PIN_COUNT-1:0] s1_d;
  logic [`PIN_COUNT-1:0] s2_d;
  // configuration finished, pins may drive and edges count
  logic run;

  assign isync = in_sync_type'(i_in_sync);
  assign omode = out_mode_type'(i_out_mode);

  // configuration done flag
  assign run = (cfg_q == CFG_RUN);

  // edge qualifier for one pin given its two-bit mode
  function automatic logic edge_hit(input logic [1:0] m, input logic r,
                                    input logic f);
    case (m)
      IRQ_RISE: edge_hit = r;
      IRQ_FALL: edge_hit = f;
      IRQ_BOTH: edge_hit = r | f;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  // level seen by one pin for the chosen synchroniser depth
  function automatic logic sync_pick(input in_sync_type s, input logic raw,
                                     input logic one, input logic two);
    case (s)
      SYNC_SINGLE: sync_pick = one;
      SYNC_TRANSPARENT: sync_pick = raw;
      default: sync_pick = two;
    endcase
  endfunction

  // data source for one pin: hardware signal if connected, else the latch
  function automatic logic source_pick(input logic conn, input logic hw,
                                       input logic dl);
    source_pick = conn ? hw : dl;
  endfunction

  // value driven on one pin for the chosen output mode
  function automatic logic drive_pick(input out_mode_type o,
                                      input logic src, input logic held,
                                      input logic gate, input logic ck);
    case (o)
      OUT_SINGLE: drive_pick = held;
      OUT_CLOCK: drive_pick = gate & ck;
      OUT_CLOCK_INV: drive_pick = gate & ~ck;
      default: drive_pick = src;
    endcase
  endfunction

  // driver enable for one pin: configured, drive on, hw enable if used
  function automatic logic enable_pick(input logic ready, input logic drv,
                                       input logic used, input logic hw_oe);
    enable_pick = ready & drv & (~used | hw_oe);
  endfunction

  // next event bit: a clear drops it, a qualified edge sets it again;
  // the set wins so an edge in the clear cycle is not lost
  function automatic logic event_next(input logic clr, input logic pend,
                                      input logic seen);
    event_next = (pend & ~clr) | seen;
  endfunction

  // configuration sequence: reset state, drive mode, then initial value
  // the count stands in for the drive mode step; pins stay undriven through it and the initial value step after it,
  // up to the run state, so no stale level reaches the pad
  always_comb begin
    cfg_d = cfg_q;
    cnt_d = cnt_q;
    case (cfg_q)
      CFG_RESET: cfg_d = CFG_DRIVE;
      CFG_DRIVE: begin
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == `CFG_DONE_CYCLES) begin
          cfg_d = CFG_INIT;
        end
      end
      CFG_INIT: cfg_d = CFG_RUN;
      CFG_RUN: cfg_d = CFG_RUN;
      default: cfg_d = CFG_RESET;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg_q <= CFG_RESET;
      cnt_q <= 4'h0;
    end else begin
      cfg_q <= cfg_d;
      cnt_q <= cnt_d;
    end
  end

  // output data latch: reset low, initial value, then software writes
  // writes before configuration ends are dropped, so an early write
  // never overwrites the initial value
  always_comb begin
    latch_d = latch_q;
    if (cfg_q == CFG_INIT) begin
      latch_d = i_init_value;
    end else if (cfg_q == CFG_RUN && i_sw_write) begin
      latch_d = i_sw_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      latch_q <= `LATCH_POR_VALUE;
    end else begin
      latch_q <= latch_d;
    end
  end

  // input synchroniser: next values of both stages
  // double sync
  always_comb begin
    s1_d = i_pin_in;
    s2_d = s1_q;
  end

  // input synchroniser flops on the block clock
  // both stages run in every mode so a mode change sees settled samples
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_q <= `ZERO_PINS;
      s2_q <= `ZERO_PINS;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  // select synchronised level per pin and gate by input buffer
  // transparent mode hands a raw asynchronous level to the edge logic;
  // whoever selects it takes on the metastability risk
  generate
    for (genvar p = 0; p < `PIN_COUNT; p++) begin : g_in
      assign lvl[p] = i_in_buf_en[p] &
        sync_pick(isync, i_pin_in[p], s1_q[p], s2_q[p]);
    end
  endgenerate

  assign o_pin_level_state = lvl;
  assign o_hw_in = lvl & i_hw_in_conn;

  // edge detect and sticky event latches
  generate
    for (genvar g = 0; g < `PIN_COUNT; g++) begin : g_edge
      assign rise[g] = lvl[g] & ~prev_q[g];
      assign fall[g] = ~lvl[g] & prev_q[g];
      assign hit[g] = edge_hit(i_irq_mode[2*g+:2], rise[g], fall[g]);
    end
  endgenerate

  // edges count only once configuration is done; levels seen while the
  // pins settle out of reset would otherwise latch false events
  assign qual = hit & {`PIN_COUNT{run}};

  // next values of previous sample, event latches and clear result
  always_comb begin
    prev_d = lvl;
    res_d = res_q;
    ev_d = ev_q;
    if (i_clear_pin_events_call) begin
      res_d = ev_q;
    end
    for (int k = 0; k < `PIN_COUNT; k++) begin
      ev_d[k] = event_next(i_clear_pin_events_call, ev_q[k], qual[k]);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prev_q <= `ZERO_PINS;
      ev_q <= `ZERO_PINS;
      res_q <= `ZERO_PINS;
    end else begin
      prev_q <= prev_d;
      ev_q <= ev_d;
      res_q <= res_d;
    end
  end

  assign o_port_irq = |ev_q;
  assign o_clear_result = res_q;

  // output source and registered stage
  // hardware data overrides the latch in the transparent and registered modes,
  // so a hw-driven pin there never shows the initial value; clock modes still gate by the latch
  generate
    for (genvar p = 0; p < `PIN_COUNT; p++) begin : g_src
      assign outsrc[p] = source_pick(i_hw_out_conn[p], i_hw_out[p],
                                     latch_q[p]);
    end
  endgenerate
  assign outr_d = outsrc;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      outr_q <= `ZERO_PINS;
    end else begin
      outr_q <= outr_d;
    end
  end

  // pin drive and driver enable per pin
  // in clock modes the data latch gates the clock, so a latch left low
  // keeps the pin quiet whatever the clock source does
  generate
    for (genvar p = 0; p < `PIN_COUNT; p++) begin : g_out
      assign pin_drv[p] = drive_pick(omode, outsrc[p], outr_q[p],
                                     latch_q[p], i_out_clock);
      assign pin_en[p] = enable_pick(run, i_drive_en[p], i_hw_oe_used[p],
                                     i_hw_oe[p]);
    end
  endgenerate

  // port outputs
  assign o_pin_out = pin_drv;
  assign o_pin_oe = pin_en;
  assign o_output_data_latch = latch_q;
  assign o_cfg_done = run;
endmodule
`default_nettype wire

//--- bench/pin_far_model.sv
// far-side signal source seen at the pins
`default_nettype none
module pin_far_model (
  input wire logic [7:0] i_lvl,
  input wire logic [7:0] i_dev_oe,
  input wire logic [7:0] i_dev_out,
  output logic [7:0] o_pin
);
  assign o_pin = (i_dev_oe & i_dev_out) | (~i_dev_oe & i_lvl);
endmodule
`default_nettype wire

//--- bench/io_pin_chk.sv
// port checker for the pin group block
`default_nettype none
module io_pin_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_pin_in,
  input wire logic [7:0] o_pin_out,
  input wire logic [7:0] o_pin_oe,
  input wire logic [7:0] i_hw_out_conn,
  input wire logic [7:0] i_hw_out,
  input wire logic [7:0] o_output_data_latch,
  input wire logic [7:0] i_in_buf_en,
  input wire logic [1:0] i_in_sync,
  input wire logic [1:0] i_out_mode,
  input wire logic i_out_clock,
  input wire logic [7:0] o_pin_level_state,
  input wire logic o_cfg_done
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // output and input path relations
  property p_lrst; $past(i_rst) |-> o_output_data_latch == 8'h00; endproperty
  a_lrst: assert property (p_lrst) else $error("latch reset");
  property p_oe; !o_cfg_done |-> o_pin_oe == 8'h00; endproperty
  a_oe: assert property (p_oe) else $error("early drive");
  property p_sw;
    i_out_mode == 2'h0 && i_hw_out_conn == 8'h00
      |-> o_pin_out == o_output_data_latch;
  endproperty
  a_sw: assert property (p_sw) else $error("latch out");
  property p_hw;
    i_out_mode == 2'h0 && i_hw_out_conn == 8'hff |-> o_pin_out == i_hw_out;
  endproperty
  a_hw: assert property (p_hw) else $error("hw out");
  property p_reg;
    i_out_mode == 2'h1 && $past(i_out_mode) == 2'h1 &&
      i_hw_out_conn == 8'hff && $past(i_hw_out_conn) == 8'hff
      |-> o_pin_out == $past(i_hw_out);
  endproperty
  a_reg: assert property (p_reg) else $error("reg out");
  property p_clk;
    i_out_mode == 2'h2
      |-> o_pin_out == ({8{i_out_clock}} & o_output_data_latch);
  endproperty
  a_clk: assert property (p_clk) else $error("clock out");
  property p_dbl;
    i_in_sync == 2'h0 && $past(i_in_sync, 2) == 2'h0 && i_in_buf_en == 8'hff
      |-> o_pin_level_state == $past(i_pin_in, 2);
  endproperty
  a_dbl: assert property (p_dbl) else $error("double sync");
  property p_raw;
    i_in_sync == 2'h2 |-> o_pin_level_state == (i_pin_in & i_in_buf_en);
  endproperty
  a_raw: assert property (p_raw) else $error("raw input");
  property p_one;
    i_in_sync == 2'h1 && i_in_buf_en == 8'hff
      |-> o_pin_level_state == $past(i_pin_in);
  endproperty
  a_one: assert property (p_one) else $error("single sync");
  c_reg: cover property (i_out_mode == 2'h1);
  c_raw: cover property (i_in_sync == 2'h2);
  c_clk: cover property (i_out_mode == 2'h2 && o_pin_out != 8'h00);
endmodule
bind io_pin_sync_and_edge_irq io_pin_chk chk_u (.*);
`default_nettype wire

//--- bench/tb.sv
// self-checking bench for the pin group block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, oclk = 1'b1, clr = 1'b0;
  logic irq, done;
  logic [7:0] lvl = 8'h00, conn = 8'h00, hwo = 8'h00, oeu = 8'h00;
  logic [7:0] hoe = 8'h00, den = 8'h00, swd = 8'h00, ben = 8'hff;
  logic [7:0] hic = 8'hff, pin, pout, poe, lat, lvs, hin, cres;
  logic [7:0] ini = 8'h5a;
  logic [1:0] isy = 2'h0, omd = 2'h0;
  logic [15:0] irm = 16'h0000;
  int fails = 0;
  int checks = 0;
  always #2 clk = ~clk;
  pin_far_model far_u (.i_lvl(lvl), .i_dev_oe(poe), .i_dev_out(pout),
    .o_pin(pin));
  io_pin_sync_and_edge_irq dut_u (.i_clk(clk), .i_rst(rst), .i_pin_in(pin),
    .o_pin_out(pout), .o_pin_oe(poe), .i_init_value(ini),
    .i_hw_out_conn(conn), .i_hw_out(hwo), .i_hw_oe_used(oeu), .i_hw_oe(hoe),
    .i_drive_en(den), .i_sw_write(wr), .i_sw_data(swd),
    .o_output_data_latch(lat), .i_in_buf_en(ben), .i_hw_in_conn(hic),
    .i_in_sync(isy), .i_out_mode(omd), .i_out_clock(oclk), .i_irq_mode(irm),
    .o_pin_level_state(lvs), .o_hw_in(hin), .i_clear_pin_events_call(clr),
    .o_clear_result(cres), .o_port_irq(irq), .o_cfg_done(done));
  // compare one value and count it
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // verdict and end of run
  task automatic test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // wait n falling edges
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // main sequence
  initial begin
    tick(16);
    rst = 1'b0;
    chk("latch", 8'h00, lat);
    chk("oe", 8'h00, poe);
    tick(10);
    chk("init", 8'h5a, lat);
    chk("pin out", 8'h5a, pout);
    den = 8'hff;
    oeu = 8'hff;
    hoe = 8'h0f;
    tick(1);
    chk("oe", 8'h0f, poe);
    den = 8'h00;
    swd = 8'hc3;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    tick(1);
    chk("sw out", 8'hc3, pout);
    conn = 8'hff;
    hwo = 8'h96;
    tick(1);
    chk("hw out", 8'h96, pout);
    omd = 2'h1;
    hwo = 8'h69;
    tick(2);
    chk("reg out", 8'h69, pout);
    omd = 2'h2;
    tick(1);
    chk("clk out", 8'hc3, pout);
    omd = 2'h3;
    tick(1);
    chk("inv out", 8'h00, pout);
    omd = 2'h0;
    conn = 8'h00;
    $display("output test done");
    isy = 2'h2;
    lvl = 8'ha5;
    tick(1);
    chk("raw in", 8'ha5, lvs);
    ben = 8'h0f;
    tick(1);
    chk("buffer off", 8'h05, lvs);
    ben = 8'hff;
    isy = 2'h0;
    lvl = 8'h3c;
    tick(1);
    chk("sync early", 8'ha5, lvs);
    tick(2);
    chk("sync", 8'h3c, lvs);
    chk("hw in", 8'h3c, hin);
    isy = 2'h1;
    lvl = 8'h81;
    chk("single early", 8'h3c, lvs);
    tick(1);
    chk("single sync", 8'h81, lvs);
    isy = 2'h0;
    $display("input test done");
    lvl = 8'h00;
    tick(4);
    for (int m = 0; m < 4; m++) begin
      clr = 1'b1;
      tick(1);
      clr = 1'b0;
      irm = {8{m[1:0]}};
      lvl = 8'hff;
      tick(4);
      chk("irq rise", {7'h00, m[0]}, {7'h00, irq});
      clr = 1'b1;
      tick(1);
      clr = 1'b0;
      tick(1);
      chk("clear", {8{m[0]}}, cres);
      lvl = 8'h00;
      tick(4);
      chk("irq fall", {7'h00, m[1]}, {7'h00, irq});
    end
    $display("interrupt test done");
    test_done();
  end
  // hang guard
  initial begin
    #20000;
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
